// ### stop_wake_pkg.sv
// Package of constants for the stop, wake-up and reset controller
package stop_wake_pkg;
    localparam logic [7:0] STOP_KEY = 8'h5A;
    localparam int RC_WDT_SEL_BIT = 5;
    localparam int WDT_RESET_SEL_BIT = 6;
    localparam logic [7:0] CLOCK_CTRL_RESET = 8'h00;
    localparam logic [7:0] KEY_REG_RESET = 8'h00;
    localparam logic [7:0] RAM_PAGE_RESET = 8'h00;
    localparam logic [7:0] BIT_START = 8'h00;
    localparam logic [7:0] BIT_TOP = 8'hFF;
    localparam logic [15:0] VECTOR_LOW_ADDR = 16'hFFFE;
    localparam logic [15:0] VECTOR_HIGH_ADDR = 16'hFFFF;
    localparam int CLK_MHZ = 200;
    localparam int OSC_MHZ = 4;
    localparam int CYC_PER_OSC = CLK_MHZ / OSC_MHZ;
    localparam int RESET_LOW_OSC = 8;
    localparam int RESET_LOW_CYC = RESET_LOW_OSC * CYC_PER_OSC;
    localparam int RESET_STAB_US = 65500;
    localparam int RESET_STAB_EXTRA_OSC = 7;
    localparam int RESET_STAB_CYC = RESET_STAB_US * CLK_MHZ + RESET_STAB_EXTRA_OSC * CYC_PER_OSC;
    typedef enum logic [5:0] {
        ST_RESET = 6'h01,
        ST_STAB = 6'h02,
        ST_VECTOR = 6'h04,
        ST_RUN = 6'h08,
        ST_STOP = 6'h10,
        ST_WAKE = 6'h20
    } wake_state_type;
endpackage

// ### stop_wake_reset_control.sv
// Stop/RC-watchdog stop wake-up and reset sequencing controller
// Behaviour
// - STOP entered only by STOP instruction after full-byte key 5Ah write
// - Stop ends on reset, external irq, counters, watch timer, watchdog, serial
// - Reset exit restores control registers to reset values, RAM untouched
// - Interrupt exit keeps RAM and control registers unchanged
// - Global enable set vectors to interrupt; clear resumes after STOP
// - Wake-up counts interval timer 00 to FF; run resumes on overflow
// - RC stop halts main oscillator, RC keeps running, state and ports held
// - RC stop entered by STOP while RC select bit is one; byte writes
// - RC stop ends only on reset, external irq or watchdog irq
// - Watchdog wake, enabled, reset-select clear, irq enable set: run handler
// - Watchdog wake, enabled, reset-select set: internal reset, full processing
// - Five reset sources: power-on, pin, watchdog, power-fail, address fail
// - Power-on and reuse options make reset pin a plain input
// - Reset clears page register and flag, main clock, periph off, wdt pfd off
// - Reset pin held low eight oscillator periods initializes state
// - After release wait 65.5 ms plus seven oscillator periods
// - Program counter loaded from vector bytes at FFFE and FFFF
// - Fetch from unimplemented code or RAM area causes system reset
`timescale 1ns/1ps
module stop_wake_reset_control #(
    parameter int STAB_CYCLES = stop_wake_pkg::RESET_STAB_CYC,
    parameter int PIN_LOW_CYCLES = stop_wake_pkg::RESET_LOW_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pins and reset sources
    input wire logic reset_pin_n_i,
    input wire logic por_option_i,
    input wire logic reset_pin_reuse_option_i,
    input wire logic power_on_reset_i,
    input wire logic power_fail_reset_i,
    input wire logic watchdog_timeout_i,
    // Core interface
    input wire logic key_write_i,
    input wire logic [7:0] key_data_i,
    input wire logic clock_ctrl_write_i,
    input wire logic [7:0] clock_ctrl_data_i,
    input wire logic stop_instr_i,
    input wire logic global_irq_enable_i,
    input wire logic watchdog_irq_enable_i,
    input wire logic fetch_i,
    input wire logic fetch_illegal_i,
    input wire logic [7:0] vector_data_i,
    // Wake-up sources
    input wire logic ext_irq_i,
    input wire logic event_counter_input_i,
    input wire logic watch_timer_i,
    input wire logic watchdog_irq_i,
    input wire logic sync_serial_i,
    input wire logic async_serial_i,
    // Basic interval timer prescaler tick
    input wire logic bit_tick_i,
    // Outputs
    output logic sys_reset_o,
    output logic cpu_run_o,
    output logic main_osc_en_o,
    output logic rc_osc_en_o,
    output logic periph_clk_en_o,
    output logic watchdog_en_o,
    output logic power_fail_detector_en_o,
    output logic [7:0] ram_page_register_o,
    output logic direct_page_flag_o,
    output logic [7:0] clock_control_register_o,
    output logic [7:0] power_down_key_register_o,
    output logic [7:0] bit_count_o,
    output logic vector_fetch_o,
    output logic [15:0] vector_addr_o,
    output logic [15:0] pc_o,
    output logic take_irq_o,
    output logic take_wdt_irq_o,
    output logic resume_next_o,
    output logic reset_shared_input_o
);
    import stop_wake_pkg::*;

    // Three-stage synchronisers; a change counts when stages two and three agree
    function automatic logic filt(input logic [2:0] s, input logic prev);
        filt = (s[1] == s[2]) ? s[2] : prev;
    endfunction

    localparam int NSYNC = 8;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sy1_ff;
    logic [NSYNC-1:0] sy2_ff;
    logic [NSYNC-1:0] sy3_ff;
    logic [NSYNC-1:0] syv_ff;
    // Bit 7 is the reset pin, which idles high; the rest idle low
    assign async_in[7] = reset_pin_n_i;
    assign async_in[6] = ext_irq_i;
    assign async_in[5] = event_counter_input_i;
    assign async_in[4] = watch_timer_i;
    assign async_in[3] = watchdog_irq_i;
    assign async_in[2] = sync_serial_i;
    assign async_in[1] = async_serial_i;
    assign async_in[0] = power_fail_reset_i;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sy1_ff <= 8'h80;
            sy2_ff <= 8'h80;
            sy3_ff <= 8'h80;
            syv_ff <= 8'h80;
        end else begin
            sy1_ff <= async_in;
            sy2_ff <= sy1_ff;
            sy3_ff <= sy2_ff;
            for (int i = 0; i < NSYNC; i++) begin
                syv_ff[i] <= filt({sy3_ff[i], sy2_ff[i], 1'b0}, syv_ff[i]);
            end
        end
    end

    wire pin_n_s = syv_ff[7];
    wire ext_s = syv_ff[6];
    wire ec_s = syv_ff[5];
    wire wt_s = syv_ff[4];
    wire wdi_s = syv_ff[3];
    wire ssp_s = syv_ff[2];
    wire asp_s = syv_ff[1];
    wire pfd_s = syv_ff[0];

    // Pin reuse: both options turn the reset pin into a plain input
    wire pin_reused = por_option_i & reset_pin_reuse_option_i;

    // Low-time counter on the reset pin; short glitches do not reset
    logic [15:0] pin_low_ff;
    wire pin_low_ok = (pin_low_ff >= 16'(PIN_LOW_CYCLES));
    wire [15:0] nxt_pin_low = (pin_n_s | pin_reused) ? 16'h0000 :
                              (pin_low_ok ? pin_low_ff : pin_low_ff + 16'h0001);

    logic [7:0] clkctl_ff;
    logic [7:0] key_ff;
    wire rc_mode = clkctl_ff[RC_WDT_SEL_BIT];
    wire wdt_rst_sel = clkctl_ff[WDT_RESET_SEL_BIT];

    wake_state_type state_ff;
    wake_state_type nxt_state;
    logic wdt_wake_ff;

    // Watchdog wake with reset-select set becomes an internal reset
    wire wdt_wake_reset = (state_ff == ST_STOP) && rc_mode && wdi_s
                          && global_irq_enable_i && wdt_rst_sel;
    // Address fail is checked only in run, so the vector phase never trips it
    wire addr_fail = fetch_i & fetch_illegal_i & (state_ff == ST_RUN);
    wire any_reset = power_on_reset_i | pin_low_ok | watchdog_timeout_i | pfd_s
                     | addr_fail | wdt_wake_reset;

    // Wake sources depend on the stop flavour
    wire wake_plain = ext_s | ec_s | wt_s | wdi_s | ssp_s | asp_s;
    // The RC flavour ignores counters and serial units: their clocks are stopped
    wire wake_rc = ext_s | wdi_s;
    wire wake_now = rc_mode ? wake_rc : wake_plain;
    wire stop_ok = stop_instr_i && (key_ff == STOP_KEY);

    logic [31:0] stab_ff;
    logic [7:0] bit_ff;
    logic vec_hi_ff;
    wire stab_done = (stab_ff >= 32'(STAB_CYCLES));
    wire bit_over = (bit_ff == BIT_TOP) & bit_tick_i;

    always_comb begin
        nxt_state = state_ff;
        // Next-state logic
        case (state_ff)
            ST_RESET: begin
                nxt_state = ST_STAB;
            end
            ST_STAB: begin
                if (stab_done) begin
                    nxt_state = ST_VECTOR;
                end
            end
            ST_VECTOR: begin
                if (vec_hi_ff) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_ok) begin
                    nxt_state = ST_STOP;
                end
            end
            ST_STOP: begin
                if (wake_now) begin
                    nxt_state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (bit_over) begin
                    nxt_state = ST_RUN;
                end
            end
            default: begin
                nxt_state = ST_RESET;
            end
        endcase
        // Any reset source overrides the sequence, whatever the state
        if (any_reset) begin
            nxt_state = ST_RESET;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= ST_RESET;
            pin_low_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            pin_low_ff <= nxt_pin_low;
        end
    end

    // Control registers: reset restores them, interrupt wake keeps them
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            clkctl_ff <= CLOCK_CTRL_RESET;
            key_ff <= KEY_REG_RESET;
        end else if (state_ff == ST_RESET) begin
            clkctl_ff <= CLOCK_CTRL_RESET;
            key_ff <= KEY_REG_RESET;
        end else begin
            // Key and clock control keep their value over an interrupt wake
            if (clock_ctrl_write_i) begin
                clkctl_ff <= clock_ctrl_data_i;
            end
            if (key_write_i) begin
                key_ff <= key_data_i;
            end
        end
    end

    // Stabilization count after reset and interval timer count after wake
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stab_ff <= 32'h00000000;
            bit_ff <= BIT_START;
        end else begin
            // A plain cycle count, long enough for the oscillator to settle
            if (state_ff == ST_STAB) begin
                stab_ff <= stab_ff + 32'h00000001;
            end else begin
                stab_ff <= 32'h00000000;
            end
            if (state_ff != ST_WAKE) begin
                bit_ff <= BIT_START;
            end else if (bit_tick_i) begin
                bit_ff <= bit_ff + 8'h01;
            end
        end
    end

    // Only a watchdog request in RC stop counts as a watchdog wake
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wdt_wake_ff <= 1'b0;
        end else if (state_ff == ST_STOP && wake_now) begin
            wdt_wake_ff <= rc_mode & wdi_s & ~ext_s;
        end
    end

    wire exit_wake = (state_ff == ST_WAKE) & bit_over;
    wire go_irq = exit_wake & global_irq_enable_i & ~wdt_wake_ff;
    wire go_wdt = exit_wake & global_irq_enable_i & wdt_wake_ff & ~wdt_rst_sel
                  & watchdog_irq_enable_i;
    wire go_next = exit_wake & ~(go_irq | go_wdt);

    // Vector fetch: low byte at FFFE then high byte at FFFF
    logic [15:0] pc_ff;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            vec_hi_ff <= 1'b0;
            pc_ff <= 16'h0000;
        end else if (state_ff == ST_VECTOR) begin
            vec_hi_ff <= ~vec_hi_ff;
            if (vec_hi_ff) begin
                pc_ff[15:8] <= vector_data_i;
            end else begin
                pc_ff[7:0] <= vector_data_i;
            end
        end else begin
            vec_hi_ff <= 1'b0;
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sys_reset_o <= 1'b1;
            cpu_run_o <= 1'b0;
            main_osc_en_o <= 1'b1;
            rc_osc_en_o <= 1'b1;
            periph_clk_en_o <= 1'b0;
            watchdog_en_o <= 1'b0;
            power_fail_detector_en_o <= 1'b0;
            ram_page_register_o <= RAM_PAGE_RESET;
            direct_page_flag_o <= 1'b0;
            vector_fetch_o <= 1'b0;
            vector_addr_o <= VECTOR_LOW_ADDR;
            take_irq_o <= 1'b0;
            take_wdt_irq_o <= 1'b0;
            resume_next_o <= 1'b0;
            reset_shared_input_o <= 1'b1;
        end else begin
            sys_reset_o <= (nxt_state == ST_RESET) || (nxt_state == ST_STAB);
            cpu_run_o <= (nxt_state == ST_RUN);
            // Stopped main oscillator in both stop flavours, RC keeps running
            main_osc_en_o <= (nxt_state != ST_STOP);
            rc_osc_en_o <= 1'b1;
            // Watchdog and detector stay off here; software enables them elsewhere
            if (nxt_state == ST_RESET) begin
                periph_clk_en_o <= 1'b0;
                watchdog_en_o <= 1'b0;
                power_fail_detector_en_o <= 1'b0;
                ram_page_register_o <= RAM_PAGE_RESET;
                direct_page_flag_o <= 1'b0;
            end else if (state_ff == ST_RUN) begin
                periph_clk_en_o <= 1'b1;
            end
            vector_fetch_o <= (nxt_state == ST_VECTOR);
            if (state_ff == ST_VECTOR && !vec_hi_ff) begin
                vector_addr_o <= VECTOR_HIGH_ADDR;
            end else begin
                vector_addr_o <= VECTOR_LOW_ADDR;
            end
            take_irq_o <= go_irq;
            take_wdt_irq_o <= go_wdt;
            resume_next_o <= go_next;
            reset_shared_input_o <= pin_n_s;
        end
    end

    assign clock_control_register_o = clkctl_ff;
    assign power_down_key_register_o = key_ff;
    assign bit_count_o = bit_ff;
    assign pc_o = pc_ff;
endmodule

// ### stop_wake_sva.sv
// Assertion checker for the stop, wake-up and reset controller
`timescale 1ns/1ps
module stop_wake_sva import stop_wake_pkg::*; (
    input wire logic clk_i, rst_i, stop_instr_i, fetch_i, fetch_illegal_i,
    input wire logic global_irq_enable_i, watchdog_irq_enable_i,
    input wire logic sys_reset_o, cpu_run_o, main_osc_en_o, rc_osc_en_o,
    input wire logic periph_clk_en_o, watchdog_en_o, power_fail_detector_en_o,
    input wire logic [7:0] ram_page_register_o, clock_control_register_o,
    input wire logic [7:0] power_down_key_register_o, bit_count_o,
    input wire logic direct_page_flag_o, vector_fetch_o, take_irq_o, take_wdt_irq_o,
    input wire logic [15:0] vector_addr_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    stop_refused_a: assert property (stop_instr_i && cpu_run_o &&
        power_down_key_register_o != STOP_KEY |-> ##2 main_osc_en_o) else $error("stop no key");
    stop_entry_a: assert property (stop_instr_i && cpu_run_o &&
        power_down_key_register_o == STOP_KEY |-> ##[1:2] !main_osc_en_o && !cpu_run_o)
        else $error("stop not entered");
    wake_count_a: assert property ($rose(cpu_run_o) && !$past(vector_fetch_o)
        |-> $past(bit_count_o) == BIT_TOP) else $error("run before overflow");
    irq_pulse_a: assert property (take_irq_o |-> global_irq_enable_i ##1 !take_irq_o)
        else $error("bad interrupt exit");
    wdt_irq_a: assert property (take_wdt_irq_o |-> global_irq_enable_i &&
        watchdog_irq_enable_i && !clock_control_register_o[WDT_RESET_SEL_BIT])
        else $error("bad watchdog exit");
    stop_hold_a: assert property (!main_osc_en_o |-> rc_osc_en_o && !cpu_run_o)
        else $error("stop state wrong");
    reset_init_a: assert property (sys_reset_o |-> ram_page_register_o == RAM_PAGE_RESET
        && !direct_page_flag_o && !periph_clk_en_o && !watchdog_en_o
        && !power_fail_detector_en_o) else $error("reset state wrong");
    vector_order_a: assert property (vector_fetch_o && vector_addr_o == VECTOR_LOW_ADDR
        |=> vector_fetch_o && vector_addr_o == VECTOR_HIGH_ADDR) else $error("vector order");
    addr_fail_a: assert property (fetch_i && fetch_illegal_i && cpu_run_o
        |-> ##[1:3] sys_reset_o) else $error("no address fail reset");
endmodule
bind stop_wake_reset_control stop_wake_sva i_stop_wake_sva (.*);

// ### wake_src_model.sv
// Model of the reset pin and the wake-up request sources
`timescale 1ns/1ps
module wake_src_model (
    input wire logic clk_i,
    output logic reset_pin_n_o,
    output logic [5:0] wake_o
);
    initial begin
        reset_pin_n_o = 1'b1;
        wake_o = 6'h00;
    end
    // Pin rests high through its pull-up between pulses
    task automatic pin_low(input int n);
        @(posedge clk_i);
        reset_pin_n_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        reset_pin_n_o <= 1'b1;
    endtask
    // Requests are levels held until served, as real sources do
    task automatic raise(input int i);
        @(posedge clk_i);
        wake_o[i] <= 1'b1;
    endtask
    task automatic drop;
        @(posedge clk_i);
        wake_o <= 6'h00;
        // Let the synchroniser see the drop before the next stop
        repeat (6) @(posedge clk_i);
    endtask
endmodule

// ### stop_wake_reset_control_tb.sv
// Self-checking bench for the stop, wake-up and reset controller
`timescale 1ns/1ps
module stop_wake_reset_control_tb;
    import stop_wake_pkg::*;
    logic clk_i = 0, rst_i = 1, por_option_i = 0, reset_pin_reuse_option_i = 0;
    logic power_on_reset_i = 0, power_fail_reset_i = 0, watchdog_timeout_i = 0;
    logic key_write_i = 0, clock_ctrl_write_i = 0, stop_instr_i = 0, fetch_i = 0;
    logic global_irq_enable_i = 0, watchdog_irq_enable_i = 0, fetch_illegal_i = 0;
    logic bit_tick_i = 0, reset_pin_n_i, sys_reset_o, cpu_run_o, main_osc_en_o;
    logic take_irq_o, take_wdt_irq_o, resume_next_o, reset_shared_input_o;
    logic [7:0] key_data_i = 0, clock_ctrl_data_i = 0, clock_control_register_o;
    logic [15:0] vector_addr_o, pc_o;
    logic periph_clk_en_o, watchdog_en_o, power_fail_detector_en_o;
    logic [7:0] ram_page_register_o, power_down_key_register_o;
    logic [5:0] wake;
    wire logic [7:0] vector_data_i = vector_addr_o[0] ? 8'hC3 : 8'h7E;
    int fails = 0, num_checks = 0, cycles = 0;
    // Rows: source, rc, irq enable, wdt irq enable, wdt reset select, exit pulses
    logic [9:0] rows [9] = '{10'b000_0_1_0_0_100, 10'b000_0_0_0_0_001,
        10'b001_0_1_0_0_100, 10'b010_0_0_0_0_001, 10'b100_0_1_0_0_100,
        10'b101_0_0_0_0_001, 10'b011_1_1_1_0_010, 10'b000_1_0_0_0_001,
        10'b011_0_0_0_0_001};
    stop_wake_reset_control #(.STAB_CYCLES(20), .PIN_LOW_CYCLES(4)) i_stop_wake_reset_control (
        .clk_i(clk_i), .rst_i(rst_i), .reset_pin_n_i(reset_pin_n_i), .por_option_i(por_option_i),
        .reset_pin_reuse_option_i(reset_pin_reuse_option_i), .power_on_reset_i(power_on_reset_i),
        .power_fail_reset_i(power_fail_reset_i), .watchdog_timeout_i(watchdog_timeout_i),
        .key_write_i(key_write_i), .key_data_i(key_data_i), .stop_instr_i(stop_instr_i),
        .clock_ctrl_write_i(clock_ctrl_write_i), .clock_ctrl_data_i(clock_ctrl_data_i),
        .global_irq_enable_i(global_irq_enable_i), .fetch_illegal_i(fetch_illegal_i),
        .watchdog_irq_enable_i(watchdog_irq_enable_i), .fetch_i(fetch_i),
        .vector_data_i(vector_data_i), .ext_irq_i(wake[0]), .event_counter_input_i(wake[1]),
        .watch_timer_i(wake[2]), .watchdog_irq_i(wake[3]), .sync_serial_i(wake[4]),
        .async_serial_i(wake[5]), .bit_tick_i(bit_tick_i), .sys_reset_o(sys_reset_o),
        .cpu_run_o(cpu_run_o), .main_osc_en_o(main_osc_en_o), .rc_osc_en_o(),
        .periph_clk_en_o(periph_clk_en_o), .watchdog_en_o(watchdog_en_o),
        .power_fail_detector_en_o(power_fail_detector_en_o),
        .ram_page_register_o(ram_page_register_o), .direct_page_flag_o(),
        .power_down_key_register_o(power_down_key_register_o),
        .clock_control_register_o(clock_control_register_o), .bit_count_o(),
        .vector_fetch_o(), .vector_addr_o(vector_addr_o), .pc_o(pc_o),
        .take_irq_o(take_irq_o), .take_wdt_irq_o(take_wdt_irq_o),
        .resume_next_o(resume_next_o), .reset_shared_input_o(reset_shared_input_o));
    wake_src_model i_wake_src_model (.clk_i(clk_i), .reset_pin_n_o(reset_pin_n_i), .wake_o(wake));
    always #2.5 clk_i = ~clk_i;
    // Tick every other cycle keeps a wake-up count short but real
    always @(posedge clk_i) bit_tick_i <= ~bit_tick_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic go_stop(input logic [7:0] ccr, key);
        @(posedge clk_i);
        key_write_i <= 1'b1;
        key_data_i <= key;
        clock_ctrl_write_i <= 1'b1;
        clock_ctrl_data_i <= ccr;
        @(posedge clk_i);
        key_write_i <= 1'b0;
        clock_ctrl_write_i <= 1'b0;
        stop_instr_i <= 1'b1;
        @(posedge clk_i);
        stop_instr_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    // Bounded wait for run, gathering the exit pulses on the way
    task automatic wait_run(output logic [2:0] seen);
        seen = 3'b000;
        for (int n = 0; n < 2000 && cpu_run_o !== 1'b1; n++) begin
            @(posedge clk_i) #1;
            seen |= {take_irq_o, take_wdt_irq_o, resume_next_o};
        end
        @(posedge clk_i) #1;
        seen |= {take_irq_o, take_wdt_irq_o, resume_next_o};
        chk(16'(cpu_run_o), 16'h1, "no run");
    endtask
    task automatic wait_rst;
        for (int n = 0; n < 800 && sys_reset_o !== 1'b1; n++) @(posedge clk_i) #1;
    endtask
    initial begin
        logic [2:0] seen;
        logic [9:0] r;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_run(seen);
        chk(pc_o, 16'hC37E, "boot vector");
        chk(16'(clock_control_register_o), 16'(CLOCK_CTRL_RESET), "ccr reset");
        chk(16'({periph_clk_en_o, watchdog_en_o, power_fail_detector_en_o}), 16'h4, "clocks");
        chk(16'(ram_page_register_o), 16'(RAM_PAGE_RESET), "page reset");
        for (int k = 0; k < 9; k++) begin
            r = rows[k];
            global_irq_enable_i <= r[5];
            watchdog_irq_enable_i <= r[4];
            go_stop({1'b0, r[3], r[6], 5'h00}, STOP_KEY);
            chk(16'(main_osc_en_o), 16'h0, "stop entry");
            i_wake_src_model.raise(int'(r[9:7]));
            wait_run(seen);
            i_wake_src_model.drop();
            chk(16'(seen), 16'(r[2:0]), "exit kind");
            chk(16'(clock_control_register_o), {9'h0, r[3], r[6], 5'h00}, "ccr kept");
            chk(16'(power_down_key_register_o), 16'(STOP_KEY), "key kept");
            $display("row %0d done", k);
        end
        go_stop(8'h00, 8'h00);
        chk(16'(main_osc_en_o), 16'h1, "stop without key");
        go_stop(8'h20, STOP_KEY);
        i_wake_src_model.raise(1);
        repeat (600) @(posedge clk_i);
        chk(16'(cpu_run_o), 16'h0, "counter woke rc stop");
        i_wake_src_model.raise(0);
        wait_run(seen);
        i_wake_src_model.drop();
        $display("rc refusal done");
        global_irq_enable_i <= 1'b1;
        go_stop(8'h60, STOP_KEY);
        i_wake_src_model.raise(3);
        wait_rst();
        i_wake_src_model.drop();
        chk(16'(sys_reset_o), 16'h1, "watchdog wake reset");
        chk(16'(periph_clk_en_o), 16'h0, "periph off in reset");
        wait_run(seen);
        chk(16'(clock_control_register_o), 16'(CLOCK_CTRL_RESET), "ccr restored");
        chk(pc_o, 16'hC37E, "vector after reset");
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            {power_on_reset_i, power_fail_reset_i, watchdog_timeout_i} <= 3'(4 >> k);
            {fetch_i, fetch_illegal_i} <= {2{k == 3}};
            repeat (3) @(posedge clk_i);
            {power_on_reset_i, power_fail_reset_i, watchdog_timeout_i} <= 3'h0;
            {fetch_i, fetch_illegal_i} <= 2'h0;
            wait_rst();
            chk(16'(sys_reset_o), 16'h1, "reset source");
            wait_run(seen);
        end
        $display("reset sources done");
        por_option_i <= 1'b1;
        reset_pin_reuse_option_i <= 1'b1;
        fork
            i_wake_src_model.pin_low(12);
            begin
                repeat (9) @(posedge clk_i) #1;
                chk(16'(reset_shared_input_o), 16'h0, "pin as input");
            end
        join
        chk(16'(sys_reset_o), 16'h0, "pin reset while reused");
        por_option_i <= 1'b0;
        reset_pin_reuse_option_i <= 1'b0;
        i_wake_src_model.pin_low(12);
        chk(16'(sys_reset_o), 16'h1, "pin reset");
        wait_run(seen);
        $display("pin tests done");
        end_sim();
    end
endmodule
